/* File: hdl/pfc_params.svh */
// constants of the permanent-fail checker
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

`define PFC_CLK_PERIOD_NS 4
`define PFC_EVAL_PERIOD_NS 1000000000
`define PFC_TICK_CYCLES (`PFC_EVAL_PERIOD_NS / `PFC_CLK_PERIOD_NS)

`define PFC_NCHK 11
`define PFC_NTHR 16

`define PFC_ADDR_CTRL 8'h00
`define PFC_ADDR_ENABLE 8'h01
`define PFC_ADDR_THR_BASE 4'h1
`define PFC_ADDR_DLY_BASE 4'h2
`define PFC_ADDR_FAIL 8'h30
`define PFC_ADDR_ALERT 8'h31
`define PFC_ADDR_BOOT 8'h32

`define PFC_CTRL_RESET 16'h0001
`define PFC_ENABLE_RESET 16'h1000
`define PFC_THR_RESET 16'h0000
`define PFC_DLY_RESET 8'h00

`define PFC_BIT_LATCHED_SHORT_CIRCUIT 11
`define PFC_BIT_CFGSIG 12

`define PFC_THR_RELAXED_IMBALANCE_FAIL_TH 8
`define PFC_THR_ACTIVE_IMBALANCE_FAIL_TH 9
`define PFC_THR_RELAXED_IMBALANCE_FAIL_CHKV 10
`define PFC_THR_RELAXED_IMBALANCE_FAIL_MAXI 11
`define PFC_THR_RELAXED_IMBALANCE_FAIL_MINDUR 12
`define PFC_THR_ACTIVE_IMBALANCE_FAIL_CHKV 13
`define PFC_THR_ACTIVE_IMBALANCE_FAIL_MINI 14

`define PFC_OTP_BLANK 8'h00
`define PFC_MANU_LO 8'he0
`define PFC_MANU_HI 8'hef
`define PFC_SAVED_LO 8'hf0
`define PFC_SAVED_HI 8'hf7

`endif

/* File: hdl/pfc_pkg.sv */
// types of the permanent-fail checker
package pfc_pkg;
  typedef logic [15:0] pfc_word_type;
  typedef logic signed [15:0] pfc_sword_type;
  typedef logic [7:0] pfc_byte_type;
  typedef enum logic [1:0] {
    PFC_BOOT_IDLE = 2'b00,
    PFC_BOOT_SCAN = 2'b01,
    PFC_BOOT_CHECK = 2'b10,
    PFC_BOOT_DONE = 2'b11
  } pfc_boot_type;
endpackage

/* File: hdl/pfc_checker.sv */
// permanent-fail checker: periodic threshold checks, boot signature and trim checks
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "pfc_params.svh"

module pfc_checker #(
  parameter int unsigned TICK_CYCLES = `PFC_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pfc_pkg::pfc_byte_type reg_addr,
  input wire pfc_pkg::pfc_word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pfc_pkg::pfc_word_type reg_rdata,
  input wire logic monitor_mode,
  input wire pfc_pkg::pfc_word_type cell_vmax,
  input wire pfc_pkg::pfc_word_type cell_vmin,
  input wire pfc_pkg::pfc_sword_type pack_current,
  input wire pfc_pkg::pfc_sword_type cell_temp_max,
  input wire pfc_pkg::pfc_sword_type switch_temp_max,
  input wire logic charge_switch_on,
  input wire logic discharge_switch_on,
  input wire logic fuse_line_in,
  input wire logic latched_short_circuit,
  input wire logic boot_start,
  input wire logic otp_word_valid,
  input wire pfc_pkg::pfc_byte_type otp_addr,
  input wire pfc_pkg::pfc_byte_type otp_data,
  input wire logic otp_last,
  input wire pfc_pkg::pfc_word_type otp_expected_sig,
  input wire logic trim_error,
  output logic safety_undervolt_fail,
  output logic safety_overvolt_fail,
  output logic safety_charge_overcurrent_fail,
  output logic safety_discharge_overcurrent_fail,
  output logic safety_cell_overtemp_fail,
  output logic safety_switch_overtemp_fail,
  output logic charge_switch_fail,
  output logic discharge_switch_fail,
  output logic secondary_protector_fail,
  output logic relaxed_imbalance_fail,
  output logic active_imbalance_fail,
  output logic latched_short_circuit_fail,
  output logic config_signature_fail,
  output logic permanent_failure,
  output logic permanent_failure_alert,
  output logic config_defaults,
  output logic switches_hold_off,
  output logic first_regulator_disable,
  output logic boot_done,
  output logic shutdown_request
);
  import pfc_pkg::*;

  function automatic logic in_range(input pfc_byte_type a, input pfc_byte_type lo,
                                    input pfc_byte_type hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // configuration registers
  logic [15:0] ctrl;
  logic [15:0] check_enable;
  pfc_word_type thr [0:`PFC_NTHR-1];
  pfc_byte_type dly [0:`PFC_NCHK-1];

  // flags
  logic [12:0] fail_flags;
  logic [`PFC_NCHK-1:0] alert_flags;
  pfc_byte_type per_cnt [0:`PFC_NCHK-1];
  pfc_byte_type relax_cnt;

  // boot
  pfc_boot_type boot_state;
  pfc_boot_type next_boot_state;
  logic [15:0] sig;
  logic otp_blank;
  logic sig_mismatch;

  logic [27:0] tick_cnt;

  // register decode
  wire logic wr_ctrl = reg_wr && (reg_addr == `PFC_ADDR_CTRL);
  wire logic wr_enable = reg_wr && (reg_addr == `PFC_ADDR_ENABLE);
  wire logic wr_thr = reg_wr && (reg_addr[7:4] == `PFC_ADDR_THR_BASE);
  wire logic in_dly = (reg_addr[7:4] == `PFC_ADDR_DLY_BASE) &&
                      (reg_addr[3:0] < 4'(`PFC_NCHK));
  wire logic wr_dly = reg_wr && in_dly;
  wire logic [3:0] reg_idx = reg_addr[3:0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= `PFC_CTRL_RESET;
      check_enable <= `PFC_ENABLE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata;
      end
      if (wr_enable) begin
        check_enable <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < `PFC_NTHR; i++) begin
      if (!nrst) begin
        thr[i] <= `PFC_THR_RESET;
      end else if (wr_thr && (reg_idx == 4'(i))) begin
        thr[i] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < `PFC_NCHK; i++) begin
      if (!nrst) begin
        dly[i] <= `PFC_DLY_RESET;
      end else if (wr_dly && (reg_idx == 4'(i))) begin
        dly[i] <= reg_wdata[7:0];
      end
    end
  end

  // read path, one cycle late; unmapped addresses read zero
  wire logic [3:0] dly_idx = in_dly ? reg_idx : 4'h0;
  wire pfc_word_type rd_value =
    (reg_addr == `PFC_ADDR_CTRL) ? ctrl :
    (reg_addr == `PFC_ADDR_ENABLE) ? check_enable :
    (reg_addr[7:4] == `PFC_ADDR_THR_BASE) ? thr[reg_idx] :
    in_dly ? {8'h00, dly[dly_idx]} :
    (reg_addr == `PFC_ADDR_FAIL) ? {3'h0, fail_flags} :
    (reg_addr == `PFC_ADDR_ALERT) ? {5'h00, alert_flags} :
    (reg_addr == `PFC_ADDR_BOOT) ? {10'h000, shutdown_request, sig_mismatch, otp_blank,
                                   boot_done, boot_state} :
    16'h0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_value : 16'h0000;
    end
  end

  // one-second evaluation tick
  wire logic tick = (tick_cnt == 28'(TICK_CYCLES - 1));
  wire logic eval_tick = tick && monitor_mode;

  always_ff @(posedge clk) begin
    if (!nrst || tick) begin
      tick_cnt <= 28'h0000000;
    end else begin
      tick_cnt <= tick_cnt + 28'h0000001;
    end
  end

  // measurement conditions
  wire logic global_fail_enable = ctrl[0];
  wire logic [12:0] chk_en = check_enable[12:0] & {13{global_fail_enable}};
  wire pfc_word_type imbalance = (cell_vmax >= cell_vmin) ? (cell_vmax - cell_vmin) : 16'h0000;
  wire pfc_sword_type abs_current = pack_current[15] ? -pack_current : pack_current;
  wire logic relax_now = (cell_vmax > thr[`PFC_THR_RELAXED_IMBALANCE_FAIL_CHKV]) &&
                         (abs_current < $signed(thr[`PFC_THR_RELAXED_IMBALANCE_FAIL_MAXI]));
  wire logic relaxed = relax_now && ({8'h00, relax_cnt} >= thr[`PFC_THR_RELAXED_IMBALANCE_FAIL_MINDUR]);
  wire logic active = (cell_vmax > thr[`PFC_THR_ACTIVE_IMBALANCE_FAIL_CHKV]) &&
                      (pack_current >= $signed(thr[`PFC_THR_ACTIVE_IMBALANCE_FAIL_MINI]));
  wire pfc_byte_type relax_inc = (relax_cnt == 8'hff) ? 8'hff : relax_cnt + 8'h01;

  // relaxation time in seconds, restarts whenever the pack is seen moving
  always_ff @(posedge clk) begin
    if (!nrst) begin
      relax_cnt <= 8'h00;
    end else if (eval_tick) begin
      relax_cnt <= relax_now ? relax_inc : 8'h00;
    end
  end

  wire logic [`PFC_NCHK-1:0] cond;
  assign cond[0] = cell_vmin <= thr[0];
  assign cond[1] = cell_vmax >= thr[1];
  assign cond[2] = pack_current >= $signed(thr[2]);
  // discharge current is negative, so its thresholds are negative too
  assign cond[3] = pack_current <= $signed(thr[3]);
  assign cond[4] = cell_temp_max >= $signed(thr[4]);
  assign cond[5] = switch_temp_max >= $signed(thr[5]);
  assign cond[6] = !charge_switch_on && (pack_current >= $signed(thr[6]));
  assign cond[7] = !discharge_switch_on && (pack_current <= $signed(thr[7]));
  assign cond[8] = fuse_line_in;
  assign cond[9] = relaxed && (imbalance >= thr[`PFC_THR_RELAXED_IMBALANCE_FAIL_TH]);
  assign cond[10] = active && (imbalance >= thr[`PFC_THR_ACTIVE_IMBALANCE_FAIL_TH]);

  // per-check persistence counters, alerts and sticky fails
  genvar gi;
  generate
    for (gi = 0; gi < `PFC_NCHK; gi++) begin : g_chk
      wire logic hit = eval_tick && chk_en[gi] && cond[gi];
      wire pfc_byte_type cnt_inc = (per_cnt[gi] == 8'hff) ? 8'hff : per_cnt[gi] + 8'h01;

      always_ff @(posedge clk) begin
        if (!nrst) begin
          per_cnt[gi] <= 8'h00;
          alert_flags[gi] <= 1'b0;
        end else if (!chk_en[gi]) begin
          per_cnt[gi] <= 8'h00;
          alert_flags[gi] <= 1'b0;
        end else if (eval_tick) begin
          // between ticks the state holds even if the input dips
          per_cnt[gi] <= cond[gi] ? cnt_inc : 8'h00;
          alert_flags[gi] <= cond[gi];
        end
      end

      // a fail only clears with a full reset
      always_ff @(posedge clk) begin
        if (!nrst) begin
          fail_flags[gi] <= 1'b0;
        end else if (hit && (cnt_inc >= dly[gi])) begin
          fail_flags[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // latched short circuit acts at once, not on the tick
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fail_flags[`PFC_BIT_LATCHED_SHORT_CIRCUIT] <= 1'b0;
    end else if (chk_en[`PFC_BIT_LATCHED_SHORT_CIRCUIT] && latched_short_circuit) begin
      fail_flags[`PFC_BIT_LATCHED_SHORT_CIRCUIT] <= 1'b1;
    end
  end

  // boot sequence: signature over the configuration image
  wire logic otp_counted = !in_range(otp_addr, `PFC_MANU_LO, `PFC_MANU_HI) &&
                           !in_range(otp_addr, `PFC_SAVED_LO, `PFC_SAVED_HI);
  wire logic scan_word = (boot_state == PFC_BOOT_SCAN) && otp_word_valid;
  wire logic [15:0] next_sig = {sig[14:0], sig[15]} ^ {8'h00, otp_data};
  wire logic mismatch_now = !otp_blank && (sig != otp_expected_sig);

  always_comb begin
    next_boot_state = boot_state;
    case (boot_state)
      PFC_BOOT_IDLE: begin
        if (boot_start) begin
          next_boot_state = PFC_BOOT_SCAN;
        end
      end
      PFC_BOOT_SCAN: begin
        if (otp_word_valid && otp_last) begin
          next_boot_state = PFC_BOOT_CHECK;
        end
      end
      PFC_BOOT_CHECK: begin
        next_boot_state = PFC_BOOT_DONE;
      end
      PFC_BOOT_DONE: begin
        next_boot_state = PFC_BOOT_DONE;
      end
      default: begin
        next_boot_state = PFC_BOOT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      boot_state <= PFC_BOOT_IDLE;
    end else begin
      boot_state <= next_boot_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || ((boot_state == PFC_BOOT_IDLE) && boot_start)) begin
      sig <= 16'h0000;
      otp_blank <= 1'b1;
    end else if (scan_word && otp_counted) begin
      sig <= next_sig;
      // the stored failure status alone must not make the image look programmed
      if (otp_data != `PFC_OTP_BLANK) begin
        otp_blank <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sig_mismatch <= 1'b0;
      config_defaults <= 1'b0;
      fail_flags[`PFC_BIT_CFGSIG] <= 1'b0;
    end else if (boot_state == PFC_BOOT_CHECK) begin
      sig_mismatch <= mismatch_now;
      // defaults are taken on a bad image whether or not the fail is enabled
      config_defaults <= mismatch_now;
      fail_flags[`PFC_BIT_CFGSIG] <= mismatch_now && chk_en[`PFC_BIT_CFGSIG];
    end
  end

  // trim faults during boot go straight to shutdown
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shutdown_request <= 1'b0;
    end else if (trim_error && (boot_state != PFC_BOOT_DONE)) begin
      shutdown_request <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      permanent_failure <= 1'b0;
      permanent_failure_alert <= 1'b0;
      boot_done <= 1'b0;
    end else begin
      permanent_failure <= |fail_flags;
      permanent_failure_alert <= |alert_flags;
      boot_done <= (boot_state == PFC_BOOT_DONE);
    end
  end

  // default image keeps both switches and the first regulator off; no fuse action here
  assign switches_hold_off = config_defaults;
  assign first_regulator_disable = config_defaults;

  assign safety_undervolt_fail = fail_flags[0];
  assign safety_overvolt_fail = fail_flags[1];
  assign safety_charge_overcurrent_fail = fail_flags[2];
  assign safety_discharge_overcurrent_fail = fail_flags[3];
  assign safety_cell_overtemp_fail = fail_flags[4];
  assign safety_switch_overtemp_fail = fail_flags[5];
  assign charge_switch_fail = fail_flags[6];
  assign discharge_switch_fail = fail_flags[7];
  assign secondary_protector_fail = fail_flags[8];
  assign relaxed_imbalance_fail = fail_flags[9];
  assign active_imbalance_fail = fail_flags[10];
  assign latched_short_circuit_fail = fail_flags[`PFC_BIT_LATCHED_SHORT_CIRCUIT];
  assign config_signature_fail = fail_flags[`PFC_BIT_CFGSIG];

endmodule

/* File: tb/pfc_sva_checker.sv */
// assertions on the permanent-fail checker ports
`timescale 1ns/1ps
module pfc_sva #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic monitor_mode,
  input wire logic latched_short_circuit,
  input wire logic trim_error,
  input wire logic boot_start,
  input wire logic safety_undervolt_fail,
  input wire logic safety_overvolt_fail,
  input wire logic latched_short_circuit_fail,
  input wire logic config_signature_fail,
  input wire logic permanent_failure,
  input wire logic config_defaults,
  input wire logic switches_hold_off,
  input wire logic first_regulator_disable,
  input wire logic shutdown_request
);
  import pfc_pkg::*;
  int unsigned cnt;
  logic tick;
  logic booted;
  logic [3:0] fv;
  assign tick = cnt == TICK_CYCLES - 1;
  assign fv = {config_signature_fail, latched_short_circuit_fail, safety_overvolt_fail,
    safety_undervolt_fail};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= 0;
      booted <= 1'b0;
    end else begin
      cnt <= tick ? 0 : cnt + 1;
      booted <= booted | boot_start;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // up to two cycles of slack after the tick phase, none before it
  sequence s_near_tick;
    $past(tick) || $past(tick, 2) || tick;
  endsequence
  a_ov_on_tick: assert property ($rose(safety_overvolt_fail) |-> s_near_tick)
    else $error("overvolt fail rose away from a tick");
  a_uv_needs_mode: assert property ($rose(safety_undervolt_fail) |->
    $past(monitor_mode) || $past(monitor_mode, 2))
    else $error("undervolt fail rose outside monitor mode");
  a_fail_sticky: assert property (1'b1 |=> ($past(fv) & fv) == $past(fv))
    else $error("a fail flag dropped");
  a_pf_follows: assert property (fv != 4'h0 |=> permanent_failure)
    else $error("permanent failure missing");
  a_sc_cause: assert property ($rose(latched_short_circuit_fail) |->
    $past(latched_short_circuit))
    else $error("short-circuit fail without cause");
  a_defaults_tie: assert property (config_defaults == switches_hold_off &&
    config_defaults == first_regulator_disable)
    else $error("default outputs disagree");
  a_sig_defaults: assert property (config_signature_fail |-> config_defaults)
    else $error("signature fail without defaults");
  a_trim_shut: assert property (trim_error && !booted && !boot_start |=>
    shutdown_request)
    else $error("trim error gave no shutdown");
  a_shut_sticky: assert property (shutdown_request |=> shutdown_request)
    else $error("shutdown request dropped");
endmodule

bind pfc_checker pfc_sva #(.TICK_CYCLES(TICK_CYCLES)) u_pfc_sva (.clk, .nrst, .monitor_mode,
  .latched_short_circuit, .trim_error, .boot_start, .safety_undervolt_fail,
  .safety_overvolt_fail, .latched_short_circuit_fail, .config_signature_fail,
  .permanent_failure, .config_defaults, .switches_hold_off, .first_regulator_disable,
  .shutdown_request);

/* File: tb/pfc_otp_feeder.sv */
// otp word source answering a boot scan
`timescale 1ns/1ps
module pfc_otp_feeder (
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic blank,
  input wire pfc_pkg::pfc_byte_type seed,
  output logic otp_word_valid,
  output pfc_pkg::pfc_byte_type otp_addr,
  output pfc_pkg::pfc_byte_type otp_data,
  output logic otp_last
);
  import pfc_pkg::*;
  logic excl;
  initial begin
    {otp_word_valid, otp_last, otp_addr, otp_data} = 18'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        for (int i = 0; i < 34; i++) begin
          excl = i >= 8 && i < 32;
          otp_word_valid <= 1'b1;
          otp_addr <= 8'(8'hd8 + i);
          otp_data <= (blank && !excl) ? 8'h00 : seed ^ 8'(i);
          otp_last <= i == 33;
          @(posedge clk);
          otp_word_valid <= 1'b0;
          otp_last <= 1'b0;
          // idle lines keep moving so a stale word never looks valid
          for (int g = 0; g < (slow ? 3 : 1); g++) begin
            otp_addr <= ~otp_addr;
            otp_data <= ~otp_data;
            @(posedge clk);
          end
        end
      end
    end
  end
endmodule

/* File: tb/pfc_checker_tb.sv */
// self-checking bench of the permanent-fail checker
`timescale 1ns/1ps
module pfc_checker_tb;
  import pfc_pkg::*;
  localparam int T = 20;
  localparam int THR [16] = '{2500, 4200, 1000, -1000, 60, 80, 50, -50, 200, 300, 3500, 20,
    0, 3500, 100, 0};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mode = 1'b1;
  logic slow = 1'b0;
  logic blank = 1'b0;
  logic chg_on, dsg_on, fuse, sc, trim, start, ov, ol, pf, pfa, cdef, hoff, rdis, bdone, shut;
  pfc_byte_type reg_addr = 8'h00;
  pfc_byte_type seed = 8'h01;
  pfc_byte_type oa, od;
  pfc_word_type reg_wdata = 16'h0000;
  pfc_word_type esig = 16'h0000;
  pfc_word_type reg_rdata, q, vmax, vmin;
  pfc_sword_type cur, ctemp, stemp;
  logic [12:0] f;
  int err_count = 0;
  int checks = 0;
  int d;
  always #2 clk = ~clk;
  pfc_checker #(.TICK_CYCLES(T)) u_pfc_checker (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .monitor_mode(mode),
    .cell_vmax(vmax), .cell_vmin(vmin), .pack_current(cur), .cell_temp_max(ctemp),
    .switch_temp_max(stemp), .charge_switch_on(chg_on), .discharge_switch_on(dsg_on),
    .fuse_line_in(fuse), .latched_short_circuit(sc), .boot_start(start),
    .otp_word_valid(ov), .otp_addr(oa), .otp_data(od), .otp_last(ol),
    .otp_expected_sig(esig), .trim_error(trim), .safety_undervolt_fail(f[0]),
    .safety_overvolt_fail(f[1]), .safety_charge_overcurrent_fail(f[2]),
    .safety_discharge_overcurrent_fail(f[3]), .safety_cell_overtemp_fail(f[4]),
    .safety_switch_overtemp_fail(f[5]), .charge_switch_fail(f[6]),
    .discharge_switch_fail(f[7]), .secondary_protector_fail(f[8]),
    .relaxed_imbalance_fail(f[9]), .active_imbalance_fail(f[10]),
    .latched_short_circuit_fail(f[11]), .config_signature_fail(f[12]),
    .permanent_failure(pf), .permanent_failure_alert(pfa), .config_defaults(cdef),
    .switches_hold_off(hoff), .first_regulator_disable(rdis), .boot_done(bdone),
    .shutdown_request(shut));
  pfc_otp_feeder u_pfc_otp_feeder (.clk, .go(start), .slow, .blank, .seed,
    .otp_word_valid(ov), .otp_addr(oa), .otp_data(od), .otp_last(ol));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input pfc_word_type s, input pfc_word_type e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input pfc_byte_type a, input int v);
    {reg_addr, reg_wdata, reg_wr} <= {a, 16'(v), 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input pfc_byte_type a, output pfc_word_type r);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe; take them once settled
    #1;
    r = reg_rdata;
    @(posedge clk);
  endtask
  task automatic do_reset;
    {vmax, vmin, cur, ctemp, stemp} <= {16'd3000, 16'd3000, 16'sd0, 16'sd25, 16'sd25};
    {chg_on, dsg_on, fuse, sc, trim, start} <= 6'b110000;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  task automatic setup(input int c, input int e, input int dl);
    do_reset();
    // thresholds and delays first: zero thresholds would trip checks on a tick
    for (int k = 0; k < 16; k++) wr(8'(16 + k), THR[k]);
    for (int k = 0; k < 11; k++) wr(8'(32 + k), dl);
    wr(8'h00, c);
    wr(8'h01, e);
  endtask
  task automatic violate(input int i);
    case (i)
      0: vmin <= 16'd2500;
      1: vmax <= 16'd4200;
      2: cur <= 16'sd1000;
      3: cur <= -16'sd1000;
      4: ctemp <= 16'sd60;
      5: stemp <= 16'sd80;
      6: {chg_on, cur} <= {1'b0, 16'sd50};
      7: {dsg_on, cur} <= {1'b0, -16'sd50};
      8: fuse <= 1'b1;
      9: {vmax, vmin} <= {16'd3700, 16'd3500};
      10: {vmax, vmin, cur} <= {16'd3800, 16'd3500, 16'sd100};
      default: sc <= 1'b1;
    endcase
  endtask
  // signature over counted words, skipping the two reserved areas
  function automatic int sig_of(input int s0);
    int s;
    s = 0;
    for (int i = 0; i < 34; i++) begin
      if (i < 8 || i > 31) s = (((s << 1) | (s >> 15)) & 16'hffff) ^ ((s0 ^ i) & 8'hff);
    end
    return s;
  endfunction
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(36935));
    do_reset();
    rd(8'h00, q);
    chk(q, 16'h0001);
    rd(8'h01, q);
    chk(q, 16'h1000);
    wr(8'h20, 16'hffff);
    rd(8'h20, q);
    chk(q, 16'h00ff);
    rd(8'h2b, q);
    chk(q, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      d = 1 + int'($urandom % 4);
      setup(1, 1 << i, d);
      violate(i);
      repeat ((d - 1) * T) @(posedge clk);
      chk(f, 16'h0000);
      repeat (T + 2) @(posedge clk);
      chk(f, 16'(1 << i));
      chk(pfa, 16'h0001);
      chk(pf, 16'h0001);
      rd(8'h31, q);
      chk(q, 16'(1 << i));
      $display("test check %0d done", i);
    end
    for (int k = 0; k < 2; k++) begin
      setup(k, 16'h1fff, 1);
      mode <= k == 0;
      sc <= k == 0;
      violate(1);
      repeat (3 * T) @(posedge clk);
      chk(f, 16'h0000);
    end
    mode <= 1'b1;
    $display("test gating done");
    setup(1, 1, 3);
    violate(0);
    repeat (2 * T) @(posedge clk);
    vmin <= 16'd3000;
    repeat (2 * T) @(posedge clk);
    rd(8'h31, q);
    chk(q, 16'h0000);
    violate(0);
    repeat (2 * T) @(posedge clk);
    chk(f, 16'h0000);
    repeat (T + 2) @(posedge clk);
    chk(f, 16'h0001);
    setup(1, 16'h0800, 1);
    violate(11);
    repeat (3) @(posedge clk);
    chk(f, 16'h0800);
    $display("test restart and latch done");
    for (int c = 0; c < 4; c++) begin
      do_reset();
      if (c == 3) wr(8'h01, 0);
      seed <= 8'($urandom) | 8'h01;
      {blank, slow} <= {c == 0, c[0]};
      @(posedge clk);
      esig <= 16'(sig_of(seed)) ^ 16'(c != 2);
      trim <= c == 0;
      @(posedge clk);
      {trim, start} <= 2'b01;
      @(posedge clk);
      start <= 1'b0;
      for (int n = 0; n < 400 && bdone !== 1'b1; n++) @(posedge clk);
      chk(bdone, 16'h0001);
      chk(cdef, 16'(c % 2));
      chk({hoff, rdis}, 16'(3 * (c % 2)));
      chk(f, 16'(c == 1) << 12);
      chk(shut, 16'(c == 0));
      $display("test boot %0d done", c);
    end
    report_and_stop();
  end
endmodule
